// ### verilog/pts_regs.svh
// register offsets, field positions and reset values of the trigger select block
// Behaviour
// - event select 110 fires at peak and bottom; 111 fires nothing.
// - sawtooth carrier: select 001 fires on the up-count match instead.
// - sawtooth carrier: select 101 fires at the peak, not the bottom.
// - select 011, second compare 0x0001, triangle carrier: one trigger per period.
// - control bit 7 picks first compare buffer transfer; 0 means synchronous.
// - bit 7 at 1: first compare write reaches working buffer at once.
// - select 100 fires at carrier peak; 101 fires at carrier bottom on a triangle carrier.
`ifndef PTS_REGS_SVH
`define PTS_REGS_SVH

// ========================================
// offsets
`define PTS_OFS_CTRL 4'h0
`define PTS_OFS_CMP1 4'h4
`define PTS_OFS_CMP2 4'h8
`define PTS_OFS_WORK 4'hc

// ========================================
// field positions
`define PTS_SEL_LSB 4
`define PTS_SEL_MSB 6
`define PTS_ASYNC_BIT 7

// ========================================
// reset values and the second compare value of the once-per-period select
`define PTS_CTRL_RST 8'h70
`define PTS_CMP_RST 16'h0000
`define PTS_CMP2_ONE 16'h0001

`endif

// ### verilog/pts_pkg.sv
// types of the trigger select block
package pts_pkg;

    // ========================================
    // carrier state from the pwm counter, same clock
    typedef struct packed {
        logic tick;
        logic up;
        logic peak;
        logic bottom;
        logic [15:0] count;
    } pts_carrier_t;

    // ========================================
    // second trigger event select codes
    typedef enum logic [2:0] {
        SEL_UP_MATCH = 3'h0,
        SEL_DN_MATCH = 3'h1,
        SEL_UPDN_MATCH = 3'h2,
        SEL_UPDN_ONCE = 3'h3,
        SEL_PEAK = 3'h4,
        SEL_BOTTOM = 3'h5,
        SEL_PEAK_BOTTOM = 3'h6,
        SEL_OFF = 3'h7
    } pts_sel_t;

    typedef enum logic [1:0] {
        RSP_OKAY = 2'h0,
        RSP_SLVERR = 2'h2
    } pts_resp_t;

endpackage

// ### verilog/pts_trigger_select.sv
// second trigger event select and first compare buffer transfer, axi4-lite slave
//
// The AXI4-Lite interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/1ps
`include "pts_regs.svh"

module pts_trigger_select #(
    parameter int CMP_W = 16
) (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // carrier from the pwm unit
    input wire logic carrier_triangle,
    input wire pts_pkg::pts_carrier_t carrier,
    // trigger side
    output logic second_trigger,
    output logic [CMP_W-1:0] first_trigger_compare_working,
    // axi4-lite write address
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // axi4-lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read address
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // axi4-lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);

    if (CMP_W != 16) begin : g_width_check
        $error("pts_trigger_select: compare width must be 16");
    end

    // ========================================
    // registers
    logic [7:0] ctrl_r;
    logic [15:0] cmp1_r;
    logic [15:0] cmp2_r;
    logic [15:0] work_r;
    logic [3:0] awaddr_r;
    logic aw_held_r;
    logic [31:0] wdata_r;
    logic [3:0] wstrb_r;
    logic w_held_r;
    logic once_fired_r;

    logic [2:0] sel_raw;
    logic async_en;
    logic do_write;
    logic wr_hit;
    logic cmp1_wr;
    logic [15:0] cmp1_nxt;

    assign sel_raw = ctrl_r[`PTS_SEL_MSB:`PTS_SEL_LSB];
    assign async_en = ctrl_r[`PTS_ASYNC_BIT];

    // ========================================
    // write channel: address and data taken in either order
    assign s_axi_awready = !aw_held_r && !s_axi_bvalid;
    assign s_axi_wready = !w_held_r && !s_axi_bvalid;
    assign do_write = aw_held_r && w_held_r && !s_axi_bvalid;
    assign wr_hit = awaddr_r == `PTS_OFS_CTRL || awaddr_r == `PTS_OFS_CMP1
        || awaddr_r == `PTS_OFS_CMP2;
    assign cmp1_wr = do_write && awaddr_r == `PTS_OFS_CMP1;

    always_comb begin
        cmp1_nxt = cmp1_r;
        if (wstrb_r[0]) begin
            cmp1_nxt[7:0] = wdata_r[7:0];
        end
        if (wstrb_r[1]) begin
            cmp1_nxt[15:8] = wdata_r[15:8];
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            aw_held_r <= 1'b0;
            awaddr_r <= 4'h0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held_r <= 1'b1;
            awaddr_r <= {s_axi_awaddr[3:2], 2'h0};
        end else if (do_write) begin
            aw_held_r <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            w_held_r <= 1'b0;
            wdata_r <= 32'h0;
            wstrb_r <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held_r <= 1'b1;
            wdata_r <= s_axi_wdata;
            wstrb_r <= s_axi_wstrb;
        end else if (do_write) begin
            w_held_r <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= pts_pkg::RSP_OKAY;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_hit ? pts_pkg::RSP_OKAY : pts_pkg::RSP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // ========================================
    // control and compare registers
    always_ff @(posedge clk) begin
        if (!nrst) begin
            ctrl_r <= `PTS_CTRL_RST;
        end else if (do_write && awaddr_r == `PTS_OFS_CTRL && wstrb_r[0]) begin
            ctrl_r <= wdata_r[7:0];
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            cmp1_r <= `PTS_CMP_RST;
        end else if (cmp1_wr) begin
            cmp1_r <= cmp1_nxt;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            cmp2_r <= `PTS_CMP_RST;
        end else if (do_write && awaddr_r == `PTS_OFS_CMP2) begin
            if (wstrb_r[0]) begin
                cmp2_r[7:0] <= wdata_r[7:0];
            end
            if (wstrb_r[1]) begin
                cmp2_r[15:8] <= wdata_r[15:8];
            end
        end
    end

    // ========================================
    // working buffer of the first compare value
    // in sync mode a compare never sees a half-updated value: copy only at the bottom; async writes land at once
    always_ff @(posedge clk) begin
        if (!nrst) begin
            work_r <= `PTS_CMP_RST;
        end else if (async_en && cmp1_wr) begin
            work_r <= cmp1_nxt;
        end else if (!async_en && carrier.bottom) begin
            work_r <= cmp1_r;
        end
    end

    assign first_trigger_compare_working = work_r;

    // ========================================
    // second trigger event select
    pts_pkg::pts_sel_t sel_eff;
    logic match;
    logic fire;

    always_comb begin
        sel_eff = pts_pkg::pts_sel_t'(sel_raw);
        if (!carrier_triangle && sel_raw == pts_pkg::SEL_DN_MATCH) begin
            sel_eff = pts_pkg::SEL_UP_MATCH;
        end
        if (!carrier_triangle && sel_raw == pts_pkg::SEL_BOTTOM) begin
            sel_eff = pts_pkg::SEL_PEAK;
        end
    end

    assign match = carrier.tick && carrier.count == cmp2_r;

    always_comb begin
        unique case (sel_eff)
            pts_pkg::SEL_UP_MATCH: fire = match && carrier.up;
            pts_pkg::SEL_DN_MATCH: fire = match && !carrier.up;
            pts_pkg::SEL_UPDN_MATCH: fire = match;
            // a match at 1 sits beside the bottom turn; one pulse per period
            pts_pkg::SEL_UPDN_ONCE: fire = match && !once_fired_r;
            pts_pkg::SEL_PEAK: fire = carrier.peak;
            pts_pkg::SEL_BOTTOM: fire = carrier.bottom;
            pts_pkg::SEL_PEAK_BOTTOM: fire = carrier.peak || carrier.bottom;
            pts_pkg::SEL_OFF: fire = 1'b0;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            once_fired_r <= 1'b0;
        end else if (carrier.peak) begin
            once_fired_r <= 1'b0;
        end else if (fire && sel_eff == pts_pkg::SEL_UPDN_ONCE && cmp2_r == `PTS_CMP2_ONE
            && carrier_triangle) begin
            once_fired_r <= 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            second_trigger <= 1'b0;
        end else begin
            second_trigger <= fire;
        end
    end

    // ========================================
    // read channel
    logic [31:0] rd_val;
    logic rd_hit;

    assign s_axi_arready = !s_axi_rvalid;

    always_comb begin
        rd_val = 32'h0;
        rd_hit = 1'b1;
        unique case ({s_axi_araddr[3:2], 2'h0})
            `PTS_OFS_CTRL: rd_val = {24'h0, ctrl_r};
            `PTS_OFS_CMP1: rd_val = {16'h0, cmp1_r};
            `PTS_OFS_CMP2: rd_val = {16'h0, cmp2_r};
            `PTS_OFS_WORK: rd_val = {16'h0, work_r};
            default: rd_hit = 1'b0;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= pts_pkg::RSP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_val;
            s_axi_rresp <= rd_hit ? pts_pkg::RSP_OKAY : pts_pkg::RSP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ========================================
    // checks
    AST_OFF_SILENT: assert property (@(posedge clk) disable iff (!nrst)
        sel_raw == 3'h7 |=> !second_trigger)
        else $error("trigger fired with select off");
    AST_PEAK_BOTTOM: assert property (@(posedge clk) disable iff (!nrst)
        sel_raw == 3'h6 && (carrier.peak || carrier.bottom) |=> second_trigger)
        else $error("peak or bottom missed with select 110");
    AST_SAW_UP: assert property (@(posedge clk) disable iff (!nrst)
        !carrier_triangle && sel_raw == 3'h1 && match && carrier.up |=> second_trigger)
        else $error("sawtooth up match missed with select 001");
    AST_SAW_PEAK: assert property (@(posedge clk) disable iff (!nrst)
        !carrier_triangle && sel_raw == 3'h5 |-> ##1 second_trigger == $past(carrier.peak))
        else $error("sawtooth select 101 not at peak");
    AST_ONCE_PERIOD: assert property (@(posedge clk) disable iff (!nrst)
        carrier_triangle && sel_raw == 3'h3 && cmp2_r == 16'h0001 && once_fired_r
        && !carrier.peak |=> !second_trigger)
        else $error("second trigger twice in one period");
    AST_SYNC_HOLD: assert property (@(posedge clk) disable iff (!nrst)
        !async_en && !carrier.bottom |=> $stable(work_r))
        else $error("working buffer moved outside bottom in sync mode");
    AST_ASYNC_NOW: assert property (@(posedge clk) disable iff (!nrst)
        async_en && cmp1_wr |=> work_r == cmp1_r)
        else $error("async write not reflected at once");
    AST_TRI_SEL: assert property (@(posedge clk) disable iff (!nrst)
        carrier_triangle && sel_raw == 3'h4 |-> ##1 second_trigger == $past(carrier.peak))
        else $error("select 100 not at peak");
    AST_TRI_BOTTOM: assert property (@(posedge clk) disable iff (!nrst)
        carrier_triangle && sel_raw == 3'h5 |-> ##1 second_trigger == $past(carrier.bottom))
        else $error("triangle select 101 not at bottom");
    AST_SYNC_COPY: assert property (@(posedge clk) disable iff (!nrst)
        !async_en && carrier.bottom |=> work_r == $past(cmp1_r))
        else $error("bottom copy of first compare missed");

endmodule

// ### tb/pts_carrier_model.sv
// carrier source model standing in for the pwm counter
`timescale 1ns/1ps

module pts_carrier_model #(
    parameter int PER = 6
) (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // control from the bench
    input wire logic run,
    input wire logic slow,
    input wire logic tri_sel,
    // carrier to the block
    output pts_pkg::pts_carrier_t carrier
);
    logic ph_r;
    logic [15:0] nc;

    // ========================================
    // counter; frozen carrier keeps events away from register writes
    always_comb begin
        if (tri_sel) begin
            nc = (carrier.up && carrier.count < 16'(PER)) ? carrier.count + 16'h1
                : carrier.count - 16'h1;
        end else begin
            nc = (carrier.count >= 16'(PER)) ? 16'h0 : carrier.count + 16'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            ph_r <= 1'b0;
            carrier <= '{tick: 1'b0, up: 1'b1, peak: 1'b0, bottom: 1'b0, count: 16'h0};
        end else begin
            carrier.tick <= 1'b0;
            carrier.peak <= 1'b0;
            carrier.bottom <= 1'b0;
            if (run) begin
                ph_r <= ~ph_r;
            end
            if (run && (!slow || ph_r)) begin
                carrier.count <= nc;
                carrier.tick <= 1'b1;
                carrier.peak <= (nc == 16'(PER));
                carrier.bottom <= (nc == 16'h0);
                carrier.up <= !tri_sel || (nc == 16'h0) || (carrier.up && nc != 16'(PER));
            end
        end
    end
endmodule

// ### tb/pwm_trigger_select_buffer_bench.sv
// self-checking bench of the trigger select block
`timescale 1ns/1ps

module pwm_trigger_select_buffer_bench;
    localparam int PER = 6;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic run = 1'b0;
    logic slow = 1'b0;
    logic tri_sel = 1'b0;
    pts_pkg::pts_carrier_t carrier;
    logic second_trigger;
    logic [15:0] working;
    logic [3:0] s_axi_awaddr = 4'h0;
    logic [3:0] s_axi_araddr = 4'h0;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic [31:0] s_axi_rdata;
    logic s_axi_awvalid = 1'b0;
    logic s_axi_wvalid = 1'b0;
    logic s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0;
    logic s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    int bad_count = 0;
    int cmp_count = 0;
    int cyc = 0;
    integer seed = 89709;
    logic [31:0] r;
    logic [2:0] m_sel = 3'h7;
    logic m_tri = 1'b0;
    logic m_async = 1'b0;
    logic [15:0] m_cmp1 = 16'h0;
    logic [15:0] m_cmp2 = 16'h0;
    logic [15:0] m_work = 16'h0;
    logic exp_q = 1'b0;
    logic lat = 1'b0;
    logic synced = 1'b0;
    logic busy = 1'b1;

    always #12.5 clk = ~clk;

    pts_trigger_select i_pts_trigger_select (.clk(clk), .nrst(nrst), .carrier_triangle(tri_sel),
        .carrier(carrier), .second_trigger(second_trigger),
        .first_trigger_compare_working(working), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

    pts_carrier_model #(.PER(PER)) i_pts_carrier_model (.clk(clk), .nrst(nrst), .run(run),
        .slow(slow), .tri_sel(tri_sel), .carrier(carrier));

    // ========================================
    // checking and expectations
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic close_out;
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    function automatic logic exp_trig(input logic [2:0] s, input pts_pkg::pts_carrier_t c);
        logic m;
        m = c.tick && (c.count == m_cmp2);
        if (!m_tri && (s == 3'h1 || s == 3'h5)) begin
            s = s - 3'h1;
        end
        case (s)
            3'h0: return m && c.up;
            3'h1: return m && !c.up;
            3'h2: return m;
            3'h3: return m && !lat;
            3'h4: return c.peak;
            3'h5: return c.bottom;
            3'h6: return c.peak || c.bottom;
            default: return 1'b0;
        endcase
    endfunction

    always @(posedge clk) begin
        cyc++;
        if (cyc == 40000) begin
            bad_count++;
            close_out();
        end
    end

    // one-shot state may be left from the last run, so trigger checks wait for a peak
    always @(posedge clk) begin
        if (nrst) begin
            if (synced) chk("trigger", second_trigger, exp_q);
            if (!busy) chk("working", working, m_work);
            exp_q = exp_trig(m_sel, carrier);
            if (carrier.peak) begin
                lat = 1'b0;
                synced = 1'b1;
            end else if (exp_q && m_sel == 3'h3 && m_tri && m_cmp2 == 16'h1) begin
                lat = 1'b1;
            end
            if (carrier.bottom && !m_async) m_work = m_cmp1;
        end
    end

    // ========================================
    // register bus
    task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
        logic aw, w;
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        aw = 1'b1;
        w = 1'b1;
        while (aw || w) begin
            @(posedge clk);
            if (aw && s_axi_awready === 1'b1) begin
                aw = 1'b0;
                s_axi_awvalid <= 1'b0;
            end
            if (w && s_axi_wready === 1'b1) begin
                w = 1'b0;
                s_axi_wvalid <= 1'b0;
            end
        end
        while (s_axi_bvalid !== 1'b1) @(posedge clk);
        chk("bresp", 32'(s_axi_bresp), 32'(er));
        s_axi_bready <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, input logic [31:0] exp);
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge clk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge clk); while (s_axi_rvalid !== 1'b1);
        chk("rdata", s_axi_rdata, exp);
        chk("rresp", 32'(s_axi_rresp), 32'h0);
        s_axi_rready <= 1'b0;
    endtask

    task automatic setup_run(input logic [2:0] s, input logic t, input logic a, input logic [15:0] k);
        @(negedge clk);
        busy = 1'b1;
        synced = 1'b0;
        @(posedge clk);
        run <= 1'b0;
        tri_sel <= t;
        repeat (2) @(posedge clk);
        r = $random(seed);
        wr(4'h0, {24'h0, a, s, 4'h0}, 2'h0);
        wr(4'h8, {16'h0, k}, 2'h0);
        wr(4'h4, r, 2'h0);
        wr(4'hc, ~r, 2'h2);
        rd(4'h0, {24'h0, a, s, 4'h0});
        rd(4'h4, {16'h0, r[15:0]});
        @(negedge clk);
        m_sel = s;
        m_tri = t;
        m_async = a;
        m_cmp2 = k;
        m_cmp1 = r[15:0];
        if (a) m_work = r[15:0];
        busy = 1'b0;
        @(posedge clk);
        run <= 1'b1;
        slow <= r[20];
        repeat (120) @(posedge clk);
    endtask

    // ========================================
    // main sequence
    initial begin
        repeat (8) @(posedge clk);
        nrst <= 1'b1;
        rd(4'h0, 32'h70);
        rd(4'h4, 32'h0);
        rd(4'h8, 32'h0);
        rd(4'hc, 32'h0);
        // partial strobe: only the upper byte lane of the second compare moves
        s_axi_wstrb <= 4'h2;
        wr(4'h8, 32'h0000abcd, 2'h0);
        s_axi_wstrb <= 4'hf;
        rd(4'h8, 32'h0000ab00);
        setup_run(3'h3, 1'b1, 1'b0, 16'h1);
        for (int i = 0; i < 16; i++) begin
            r = $random(seed);
            setup_run(i[3:1], i[0], r[0], i[3:1] == 3'h3 ? 16'h1 : 16'(1 + r[11:8] % (PER - 1)));
        end
        close_out();
    end
endmodule
